//--- hw/eeprom_link_pkg.sv
`default_nettype none
package eeprom_link_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_HZ       = 20_000_000;
   localparam int NV_WRITE_TIME_US  = 10_000;   // Longest nonvolatile cycle, 10 ms
   localparam int NV_WRITE_CYC      = NV_WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int SYNC_STAGES       = 2;

   // ----------------------------------------------------------------
   // Slave address byte and addressing
   // ----------------------------------------------------------------
   localparam logic [2:0] TYPE_PREFIX  = 3'h5;    // Upper three bits of 1010 / 1011
   localparam logic [1:0] SEL_ZERO     = 2'h0;
   localparam logic [8:0] CTRL_ADDR    = 9'h1FF;
   localparam logic [1:0] IDX_DEV      = 2'h0;
   localparam logic [1:0] IDX_WORD     = 2'h1;
   localparam logic [1:0] IDX_DATA     = 2'h2;
   localparam logic [1:0] IDX_EXTRA    = 2'h3;
   localparam logic [3:0] BIT_COUNT    = 4'h8;

   // ----------------------------------------------------------------
   // Control register layout: 0 wd_hi wd_lo bp_mid bp_lo register_write_enable_latch wel bp_hi
   // ----------------------------------------------------------------
   localparam int POS_WD_HI   = 6;
   localparam int POS_WD_LO   = 5;
   localparam int POS_BP_MID  = 4;
   localparam int POS_BP_LO   = 3;
   localparam int POS_REGISTER_WRITE_ENABLE_LATCH    = 2;
   localparam int POS_WEL     = 1;
   localparam int POS_BP_HI   = 0;
   localparam logic [7:0] CMD_CLR_WEL  = 8'h00;
   localparam logic [7:0] CMD_SET_WEL  = 8'h02;
   localparam logic [7:0] CMD_SET_REGISTER_WRITE_ENABLE_LATCH = 8'h06;

   // Watchdog period codes
   localparam logic [1:0] WDOG_1400MS  = 2'h0;
   localparam logic [1:0] WDOG_600MS   = 2'h1;
   localparam logic [1:0] WDOG_200MS   = 2'h2;
   localparam logic [1:0] WDOG_OFF     = 2'h3;   // Factory value
   localparam logic [2:0] PROTECT_NONE = 3'h0;   // Factory value

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] wdog_period;
      logic [2:0] protect_sel;
   } ctrl_fields_t;

   typedef struct packed {
      logic       we;
      logic [8:0] addr;
      logic [7:0] data;
   } mem_wr_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RX   = 6'h02,
      ST_ACK  = 6'h04,
      ST_TX   = 6'h08,
      ST_MACK = 6'h10,
      ST_BUSY = 6'h20
   } link_state_t;

endpackage
`default_nettype wire

//--- hw/pin_sync.sv
`default_nettype none
module pin_sync
   import eeprom_link_pkg::*;
#(
   parameter int W = 3
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   // Two-stage capture of asynchronous pins, idle high
   always_comb begin
      meta_d = pin_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_q <= '1;
         sync_o <= '1;
      end else begin
         meta_q <= meta_d;
         sync_o <= sync_d;
      end
   end
endmodule // pin_sync
`default_nettype wire

//--- hw/protect_decode.sv
`default_nettype none
module protect_decode
   import eeprom_link_pkg::*;
(
   input  wire logic [8:0] addr_i,
   input  wire logic [2:0] sel_i,
   output logic            hit_o
);
   // Maps the protect selector to a locked address range
   always_comb begin
      unique case (sel_i)
         3'h0:    hit_o = 1'b0;
         3'h1:    hit_o = (addr_i >= 9'h180);
         3'h2:    hit_o = (addr_i >= 9'h100);
         3'h3:    hit_o = 1'b1;
         3'h4:    hit_o = (addr_i <= 9'h00F);
         3'h5:    hit_o = (addr_i <= 9'h01F);
         3'h6:    hit_o = (addr_i <= 9'h03F);
         default: hit_o = (addr_i <= 9'h07F);
      endcase
   end
endmodule // protect_decode
`default_nettype wire

//--- hw/serial_eeprom_ctrl_reg_slave.sv
`default_nettype none
module serial_eeprom_ctrl_reg_slave
   import eeprom_link_pkg::*;
#(
   parameter int NV_CYCLES = NV_WRITE_CYC
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   output logic              sda_o,
   output logic              sda_oe_o,
   input  wire logic         wp_i,
   input  wire logic [7:0]   mem_rdata_i,
   output logic [8:0]        mem_addr_o,
   output mem_wr_t           mem_wr_o,
   output ctrl_fields_t      cfg_o,
   output logic              busy_o
);
   localparam int CW = $clog2(NV_CYCLES + 1);
   localparam logic [CW-1:0] BUSY_LOAD = CW'(NV_CYCLES - 1);
   // ----------------------------------------------------------------
   // Pin capture and bus conditions
   // ----------------------------------------------------------------
   logic scl_s, sda_s, wp_s;
   logic scl_p_q, sda_p_q;
   logic start_det, stop_det, scl_rise, scl_fall;
   logic prot_hit;
   pin_sync #(.W(3)) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({scl_i, sda_i, wp_i}),
      .sync_o    ({scl_s, sda_s, wp_s})
   );
   // Conditions seen on synchronised pins
   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   link_state_t     state_q, state_d;
   logic [3:0]      cnt_q, cnt_d;
   logic [1:0]      idx_q, idx_d;
   logic [7:0]      sh_q, sh_d;
   logic [7:0]      wdata_q, wdata_d;
   logic [8:0]      addr_q, addr_d;
   logic [CW-1:0]   bcnt_q, bcnt_d;
   logic            oe_q, oe_d;
   logic            sel_ctrl_q, sel_ctrl_d;
   logic            addr_hi_q, addr_hi_d;
   logic            rw_q, rw_d;
   logic            ctrl_hit_q, ctrl_hit_d;
   logic            pend_q, pend_d;
   logic            mack_q, mack_d;
   logic            wel_q, wel_d;
   logic            register_write_enable_latch_q, register_write_enable_latch_d;
   logic            busy_q, busy_d;
   ctrl_fields_t    cfg_q, cfg_d;
   mem_wr_t         mwr_q, mwr_d;
   logic [7:0]      ctrl_rd;
   logic [7:0]      rx_byte;
   logic            ack;
   logic            nv_go;
   protect_decode u_prot (
      .addr_i (addr_q),
      .sel_i  (cfg_q.protect_sel),
      .hit_o  (prot_hit)
   );
   // Register image as read back; bit 7 always zero
   always_comb begin
      ctrl_rd             = 8'h00;
      ctrl_rd[POS_WD_HI]  = cfg_q.wdog_period[1];
      ctrl_rd[POS_WD_LO]  = cfg_q.wdog_period[0];
      ctrl_rd[POS_BP_MID] = cfg_q.protect_sel[1];
      ctrl_rd[POS_BP_LO]  = cfg_q.protect_sel[0];
      ctrl_rd[POS_REGISTER_WRITE_ENABLE_LATCH]   = register_write_enable_latch_q;
      ctrl_rd[POS_WEL]    = wel_q;
      ctrl_rd[POS_BP_HI]  = cfg_q.protect_sel[2];
   end
   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      idx_d      = idx_q;
      sh_d       = sh_q;
      wdata_d    = wdata_q;
      addr_d     = addr_q;
      bcnt_d     = bcnt_q;
      oe_d       = oe_q;
      sel_ctrl_d = sel_ctrl_q;
      addr_hi_d  = addr_hi_q;
      rw_d       = rw_q;
      ctrl_hit_d = ctrl_hit_q;
      pend_d     = pend_q;
      mack_d     = mack_q;
      wel_d      = wel_q;
      register_write_enable_latch_d     = register_write_enable_latch_q;
      cfg_d      = cfg_q;
      mwr_d      = mwr_q;
      mwr_d.we   = 1'b0;
      rx_byte    = sh_q;
      ack        = 1'b0;
      nv_go      = 1'b0;
      if (state_q == ST_BUSY) begin
         // Internal write: pins ignored, data line released
         if (bcnt_q == '0) begin
            state_d = ST_IDLE;
         end else begin
            bcnt_d = bcnt_q - 1'b1;
         end
      end else if (start_det) begin
         state_d = ST_RX;
         cnt_d   = 4'h0;
         idx_d   = IDX_DEV;
         oe_d    = 1'b0;
         pend_d  = 1'b0;
      end else if (stop_det) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
         pend_d  = 1'b0;
         // Stop right after an acknowledged data byte launches the write
         if (state_q == ST_RX && cnt_q == 4'h1 && idx_q == IDX_EXTRA && pend_q) begin
            if (!sel_ctrl_q) begin
               mwr_d   = '{we: 1'b1, addr: addr_q, data: wdata_q};
               addr_d  = addr_q + 9'h001;
               state_d = ST_BUSY;
               bcnt_d  = BUSY_LOAD;
            end else if (register_write_enable_latch_q) begin
               if (!wdata_q[POS_REGISTER_WRITE_ENABLE_LATCH] && wdata_q[POS_WEL]) begin
                  cfg_d.wdog_period = {wdata_q[POS_WD_HI], wdata_q[POS_WD_LO]};
                  cfg_d.protect_sel = {wdata_q[POS_BP_HI], wdata_q[POS_BP_MID],
                                       wdata_q[POS_BP_LO]};
                  register_write_enable_latch_d  = 1'b0;
                  nv_go   = 1'b1;
                  state_d = ST_BUSY;
                  bcnt_d  = BUSY_LOAD;
               end else if (wdata_q == CMD_CLR_WEL) begin
                  wel_d = 1'b0;
               end
               // Bit 2 set: fields and latch left as they are
            end else begin
               unique case (wdata_q)
                  CMD_SET_WEL:  wel_d = 1'b1;
                  CMD_CLR_WEL:  wel_d = 1'b0;
                  CMD_SET_REGISTER_WRITE_ENABLE_LATCH: begin
                     wel_d  = 1'b1;
                     register_write_enable_latch_d = 1'b1;
                  end
                  default:      wel_d = wel_q;
               endcase
            end
         end
      end else begin
         unique case (state_q)
            ST_IDLE: oe_d = 1'b0;
            ST_RX: begin
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BIT_COUNT) begin
                  unique case (idx_q)
                     IDX_DEV: begin
                        ack = (rx_byte[7:5] == TYPE_PREFIX) &&
                              (rx_byte[3:2] == SEL_ZERO);
                        sel_ctrl_d = rx_byte[4];
                        addr_hi_d  = rx_byte[1];
                        rw_d       = rx_byte[0];
                     end
                     IDX_WORD: begin
                        ack        = 1'b1;
                        ctrl_hit_d = ({addr_hi_q, rx_byte} == CTRL_ADDR);
                        if (!sel_ctrl_q) begin
                           addr_d = {addr_hi_q, rx_byte};
                        end
                     end
                     IDX_DATA: begin
                        wdata_d = rx_byte;
                        if (sel_ctrl_q) begin
                           ack = !wp_s && ctrl_hit_q &&
                                 (wel_q || rx_byte == CMD_SET_WEL);
                        end else begin
                           ack = wel_q && !wp_s && !prot_hit;
                           if (wel_q && !wp_s && prot_hit) begin
                              register_write_enable_latch_d = 1'b0;
                           end
                        end
                        pend_d = ack;
                     end
                     default: pend_d = 1'b0;
                  endcase
                  state_d = ack ? ST_ACK : ST_IDLE;
                  oe_d    = ack;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  oe_d  = 1'b0;
                  cnt_d = 4'h0;
                  idx_d = (idx_q == IDX_EXTRA) ? IDX_EXTRA : idx_q + 2'h1;
                  if (idx_q == IDX_DEV && rw_q) begin
                     sh_d    = sel_ctrl_q ? ctrl_rd : mem_rdata_i;
                     oe_d    = ~sh_d[7];
                     state_d = ST_TX;
                  end else begin
                     state_d = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == BIT_COUNT) begin
                     oe_d    = 1'b0;
                     state_d = ST_MACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_d[7];
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_d = ~sda_s;
                  if (!sel_ctrl_q) begin
                     addr_d = addr_q + 9'h001;
                  end
               end else if (scl_fall) begin
                  if (mack_q && !sel_ctrl_q) begin
                     sh_d    = mem_rdata_i;
                     oe_d    = ~sh_d[7];
                     cnt_d   = 4'h0;
                     state_d = ST_TX;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
      busy_d = (state_d == ST_BUSY);
   end
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 4'h0;
         idx_q      <= IDX_DEV;
         sh_q       <= 8'h00;
         wdata_q    <= 8'h00;
         addr_q     <= 9'h000;
         bcnt_q     <= '0;
         oe_q       <= 1'b0;
         sel_ctrl_q <= 1'b0;
         addr_hi_q  <= 1'b0;
         rw_q       <= 1'b0;
         ctrl_hit_q <= 1'b0;
         pend_q     <= 1'b0;
         mack_q     <= 1'b0;
         wel_q      <= 1'b0;
         register_write_enable_latch_q     <= 1'b0;
         busy_q     <= 1'b0;
         cfg_q      <= '{wdog_period: WDOG_OFF, protect_sel: PROTECT_NONE};
         mwr_q      <= '0;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         idx_q      <= idx_d;
         sh_q       <= sh_d;
         wdata_q    <= wdata_d;
         addr_q     <= addr_d;
         bcnt_q     <= bcnt_d;
         oe_q       <= oe_d;
         sel_ctrl_q <= sel_ctrl_d;
         addr_hi_q  <= addr_hi_d;
         rw_q       <= rw_d;
         ctrl_hit_q <= ctrl_hit_d;
         pend_q     <= pend_d;
         mack_q     <= mack_d;
         wel_q      <= wel_d;
         register_write_enable_latch_q     <= register_write_enable_latch_d;
         busy_q     <= busy_d;
         cfg_q      <= cfg_d;
         mwr_q      <= mwr_d;
         scl_p_q    <= scl_s;
         sda_p_q    <= sda_s;
      end
   end
   // Outputs
   assign sda_o      = 1'b0;
   assign sda_oe_o   = oe_q;
   assign mem_addr_o = addr_q;
   assign mem_wr_o   = mwr_q;
   assign cfg_o      = cfg_q;
   assign busy_o     = busy_q;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_wel_powerup: assert property ($fell(sys_rst_i) |-> !wel_q && !oe_q)
      else $error("write enable or data drive active after reset");
   a_array_ack_gate: assert property (
      (state_q == ST_RX && scl_fall && cnt_q == BIT_COUNT && idx_q == IDX_DATA
       && !sel_ctrl_q && (!wel_q || wp_s || prot_hit)) |=> !oe_q && state_q == ST_IDLE)
      else $error("blocked array write was acknowledged");
   a_nv_needs_register_write_enable_latch: assert property (
      (cfg_q != $past(cfg_q)) |-> $past(register_write_enable_latch_q, 2))
      else $error("control fields changed without register write enable");
   a_nv_clears: assert property (nv_go |=> !register_write_enable_latch_q ##1 busy_o [*3])
      else $error("control update did not clear enable or start busy");
   a_register_write_enable_latch_fall: assert property ($fell(register_write_enable_latch_q) |-> $past(nv_go || (wel_q && prot_hit)))
      else $error("register write enable cleared without cause");
   a_extra_nack: assert property (
      (state_q == ST_RX && scl_fall && cnt_q == BIT_COUNT && idx_q == IDX_EXTRA)
      |=> state_q == ST_IDLE && !oe_q)
      else $error("second data byte acknowledged");
   a_busy_quiet: assert property (busy_q |-> !oe_q ##1 (!oe_q && state_q != ST_RX))
      else $error("data line driven during internal write");
   a_start_rx: assert property ((start_det && !busy_q && state_q != ST_BUSY)
      |=> state_q == ST_RX && cnt_q == 4'h0 && idx_q == IDX_DEV)
      else $error("start not taken");
   a_ctrl_one_byte: assert property (
      (state_q == ST_MACK && sel_ctrl_q && scl_fall) |=> state_q == ST_IDLE)
      else $error("register read continued past one byte");
endmodule // serial_eeprom_ctrl_reg_slave
`default_nettype wire

//--- dv/link_master.sv
`default_nettype none
module link_master (
   output logic      scl_o,
   output logic      sda_o,
   input  wire logic dev_oe_i,
   input  wire logic dev_sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hold_low;
   // Wired data line with pull-up
   assign sda_o = !hold_low & (!dev_oe_i | dev_sda_i);
   initial begin
      scl_o = 1'b1;
      hold_low = 1'b0;
   end
   // One clock: data set while low, sampled mid-high
   task automatic bit_io(input logic v, output logic s);
      #100 hold_low = !v;
      #100 scl_o = 1'b1;
      #100 s = sda_o;
      #100 scl_o = 1'b0;
   endtask
   // Start, also usable as repeated start
   task automatic start();
      #200 hold_low = 1'b0;
      #100 scl_o = 1'b1;
      #100 hold_low = 1'b1;
      #100 scl_o = 1'b0;
   endtask
   // Stop once the line is released
   task automatic stop();
      #100 hold_low = 1'b1;
      #100 scl_o = 1'b1;
      #100 hold_low = 1'b0;
   endtask
   task automatic put(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic get(input logic mack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(!mack, s);
   endtask
endmodule // link_master
`default_nettype wire

//--- dv/serial_eeprom_ctrl_reg_slave_tb_top.sv
`default_nettype none
module serial_eeprom_ctrl_reg_slave_tb_top;
   import eeprom_link_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         wp = 1'b0;
   logic         scl, sda, dsda, oe, busy, write_enable_latch, register_write_enable_latch, a, b;
   logic [8:0]   maddr, ad;
   mem_wr_t      mwr;
   ctrl_fields_t cfg;
   logic [7:0]   mem [512];
   logic [7:0]   exp_mem [512];
   logic [7:0]   bad [3] = '{8'hA8, 8'hC0, 8'h94};
   logic [8:0]   tbl [3] = '{9'h010, 9'h07F, 9'h180};
   logic [31:0]  seed = 32'hBB5C;
   logic [1:0]   wd;
   logic [2:0]   bp;
   logic [7:0]   d;
   int           num_errors = 0;
   int           check_count = 0;
   always #25 clk = !clk;
   // Array model
   always @(posedge clk) if (mwr.we) mem[mwr.addr] <= mwr.data;
   link_master u_link_master (.scl_o(scl), .sda_o(sda), .dev_oe_i(oe), .dev_sda_i(dsda));
   serial_eeprom_ctrl_reg_slave #(.NV_CYCLES(16)) u_serial_eeprom_ctrl_reg_slave (
      .clk_i(clk), .sys_rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(dsda), .sda_oe_o(oe),
      .wp_i(wp), .mem_rdata_i(mem[maddr]), .mem_addr_o(maddr), .mem_wr_o(mwr),
      .cfg_o(cfg), .busy_o(busy));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic prot(input logic [2:0] c, input logic [8:0] x);
      case (c)
         3'h1: return x >= 9'h180;
         3'h2: return x >= 9'h100;
         3'h3: return 1'b1;
         3'h4: return x <= 9'h00F;
         3'h5: return x <= 9'h01F;
         3'h6: return x <= 9'h03F;
         3'h7: return x <= 9'h07F;
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [7:0] img();
      return {1'b0, wd, bp[1:0], register_write_enable_latch, write_enable_latch, bp[2]};
   endfunction
   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Framed one-byte write; data ack and busy seen
   task automatic wr(input logic [7:0] dv, wa, dt, output logic ack, bz);
      logic a0, a1;
      @(posedge clk) #1;
      u_link_master.start();
      u_link_master.put(dv, a0);
      u_link_master.put(wa, a1);
      chk("addr_ack", 9'h3, {a0, a1});
      u_link_master.put(dt, ack);
      u_link_master.stop();
      bz = 1'b0;
      repeat (10) @(posedge clk) #1 bz |= busy;
      repeat (40) if (busy !== 1'b0) @(posedge clk) #1;
      chk("busy_end", 1'b0, busy);
   endtask
   task automatic cw(input logic [7:0] dt);
      wr(8'hB2, 8'hFF, dt, a, b);
   endtask
   // Random read through a dummy write
   task automatic rd(input logic [7:0] dv, wa, output logic [7:0] dt);
      logic x;
      @(posedge clk) #1;
      u_link_master.start();
      u_link_master.put(dv, x);
      u_link_master.put(wa, x);
      u_link_master.start();
      u_link_master.put(dv | 8'h01, x);
      chk("rd_ack", 1'b1, x);
      u_link_master.get(1'b0, dt);
      u_link_master.stop();
      repeat (4) @(posedge clk);
   endtask
   // Full enabling sequence ending in a field store
   task automatic setcfg(input logic [1:0] w, input logic [2:0] p);
      cw(8'h02);
      cw(8'h06);
      seed = lfsr(seed);
      cw({seed[7], w, p[1:0], 2'b01, p[2]});
      chk("store", 9'h3, {a, b});
      wd = w;
      bp = p;
      register_write_enable_latch = 1'b0;
      chk("cfg", {wd, bp}, cfg);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      wd = WDOG_OFF;
      bp = PROTECT_NONE;
      write_enable_latch = 1'b0;
      register_write_enable_latch = 1'b0;
      foreach (mem[i]) mem[i] = 8'h00;
      foreach (exp_mem[i]) exp_mem[i] = 8'h00;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      rd(8'hB2, 8'hFF, d);
      chk("ctrl_reset", img(), d);
      wr(8'hA0, 8'h10, 8'h5A, a, b);
      chk("wel_clear", 9'h0, {a, b});
      wp = 1'b1;
      cw(8'h02);
      chk("wp_block", 1'b0, a);
      wp = 1'b0;
      foreach (bad[i]) begin
         @(posedge clk) #1;
         u_link_master.start();
         u_link_master.put(bad[i], a);
         chk("bad_addr", 1'b0, a);
         u_link_master.stop();
      end
      cw(8'h02);
      chk("wel_set", 9'h2, {a, b});
      write_enable_latch = 1'b1;
      @(posedge clk) #1;
      u_link_master.start();
      u_link_master.put(8'hB2, a);
      u_link_master.put(8'hFF, a);
      u_link_master.put(8'h02, a);
      u_link_master.put(8'h02, a);
      chk("second_byte", 1'b0, a);
      u_link_master.stop();
      cw(8'h06);
      register_write_enable_latch = 1'b1;
      rd(8'hB2, 8'hFF, d);
      chk("ctrl_mid", img(), d);
      cw(8'h06);
      rd(8'hB2, 8'hFF, d);
      chk("keep_cfg", {img(), 1'b0}, {d, 1'b0} | {cfg !== {wd, bp}});
      for (int c = 0; c < 8; c++) begin
         setcfg(2'(c), 3'(c));
         cw(8'h02);
         cw(8'h06);
         register_write_enable_latch = 1'b1;
         for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            ad = (k < 3) ? tbl[k] : seed[8:0];
            wr({6'h28, ad[8], 1'b0}, ad[7:0], seed[23:16], a, b);
            chk("prot_ack", {2{!prot(bp, ad)}}, {a, b});
            if (a) exp_mem[ad] = seed[23:16];
            if (!a) register_write_enable_latch = 1'b0;
            rd({6'h28, ad[8], 1'b0}, ad[7:0], d);
            chk("mem_rd", exp_mem[ad], d);
         end
         rd(8'hB2, 8'hFF, d);
         chk("ctrl_img", img(), d);
      end
      // Sequential read of two bytes, then write enable cleared
      @(posedge clk) #1;
      u_link_master.start();
      u_link_master.put(8'hA0, a);
      u_link_master.put(8'h10, a);
      u_link_master.start();
      u_link_master.put(8'hA1, a);
      u_link_master.get(1'b1, d);
      chk("seq_rd0", exp_mem[9'h010], d);
      u_link_master.get(1'b0, d);
      chk("seq_rd1", exp_mem[9'h011], d);
      u_link_master.stop();
      cw(8'h00);
      chk("wel_clr", 9'h2, {a, b});
      write_enable_latch = 1'b0;
      wr(8'hA2, 8'hA0, 8'hC3, a, b);
      chk("wel_gone", 9'h0, {a, b});
      rd(8'hB2, 8'hFF, d);
      chk("ctrl_end", img(), d);
      stop_test();
   end
   // Watchdog against a hung bus
   initial begin
      #3_500_000;
      num_errors++;
      stop_test();
   end
endmodule // serial_eeprom_ctrl_reg_slave_tb_top
`default_nettype wire
